// file: rtl/cache_line_valid.sv
// valid bits of the internal cache lines
`timescale 1ns/1ps
`default_nettype none
module cache_line_valid
	import fpu_trap_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic cache_enable,
	input wire logic fill,
	input wire logic [LINE_IDX_WIDTH-1:0] fill_index,
	input wire logic flush,
	input wire logic [LINE_IDX_WIDTH-1:0] lookup_index,
	output logic lookup_valid,
	output logic any_valid
);

	logic [LINE_COUNT-1:0] valid_q;
	logic [LINE_COUNT-1:0] valid_d;
	logic [LINE_COUNT-1:0] fill_mask;

	assign fill_mask = (fill && cache_enable) ? (LINE_COUNT'(1) << fill_index) : '0;
	assign valid_d = flush ? '0 : (valid_q | fill_mask);
	// a disabled cache never reports a hit
	assign lookup_valid = cache_enable & valid_q[lookup_index];
	assign any_valid = |valid_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			valid_q <= '0;
		end else if (ce) begin
			valid_q <= valid_d;
		end
	end

endmodule : cache_line_valid
`default_nettype wire

// file: rtl/fpu_trap_and_cache_enable_control.sv
// floating-point trap routing, cache enable and model register control
// Function
// - reset clears the emulation-trap, monitor-wait and native-error flags.
// - emulation-trap set makes every float instruction fault instead of executing.
// - monitor-wait clear lets wait instructions ignore the task-switched flag.
// - monitor-wait and task-switched both set make wait instructions fault.
// - native-error set gives internal fault; clear gives external interrupt request.
// - caches run only with both cache flags clear; reset sets both.
// - after reset every internal cache line is invalid.
// - model registers are read and written by dedicated instructions.
// - range register value zero selects uncached; reset clears them all.
`timescale 1ns/1ps
`default_nettype none
module fpu_trap_and_cache_enable_control
	import fpu_trap_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	// instruction port from the core
	input wire logic instr_valid,
	input wire logic [KIND_WIDTH-1:0] instr_kind,
	input wire logic [MODEL_IDX_WIDTH-1:0] instr_model_index,
	input wire logic [31:0] instr_model_wdata,
	input wire logic task_switch,
	output logic instr_done,
	output logic fpu_issue,
	output logic wait_complete,
	output logic device_unavailable_fault,
	output logic [31:0] model_rdata,
	// floating-point exception from the unit
	input wire logic fp_unmasked_exc,
	input wire logic ext_irq_ack,
	output logic fp_error_fault,
	output logic ext_fp_irq,
	// caches
	input wire logic line_fill,
	input wire logic [LINE_IDX_WIDTH-1:0] line_fill_index,
	input wire logic cache_flush,
	input wire logic [LINE_IDX_WIDTH-1:0] lookup_index,
	output logic cache_enable,
	output logic line_hit,
	output logic [RANGE_COUNT-1:0] range_uncached
);

	logic [31:0] ctrl_q;
	logic [31:0] ctrl_d;
	logic [EV_WIDTH-1:0] status_q;
	logic [EV_WIDTH-1:0] status_d;
	logic [EV_WIDTH-1:0] mask_q;
	logic [MODEL_IDX_WIDTH-1:0] index_q;
	logic [31:0] model_q [MODEL_COUNT];
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;

	// outcome pulse flops
	logic fault_q;
	logic fpu_issue_q;
	logic wait_done_q;
	logic instr_done_q;
	logic fp_error_q;
	logic ext_irq_q;
	logic ext_irq_d;

	// result of the last model register read instruction
	logic [31:0] model_rdata_q;

	// any line valid, shown in the cache status word
	logic any_valid;

	// flags of the primary control register
	wire emulation_trap_flag = ctrl_q[EMULATION_TRAP_BIT];
	wire monitor_wait_flag = ctrl_q[MONITOR_WAIT_BIT];
	wire native_error_flag = ctrl_q[NATIVE_ERROR_BIT];
	wire task_switched_flag = ctrl_q[TASK_SWITCHED_BIT];
	wire cache_disable_flag = ctrl_q[CACHE_DISABLE_BIT];
	wire not_write_through_flag = ctrl_q[NOT_WRITE_THROUGH_BIT];

	// APB decode
	wire setup_phase = psel & ~penable;
	wire access_phase = psel & penable;
	wire sel_ctrl = (paddr == CTRL_OFF);
	wire sel_status = (paddr == IRQ_STATUS_OFF);
	wire sel_mask = (paddr == IRQ_MASK_OFF);
	wire sel_index = (paddr == MODEL_INDEX_OFF);
	wire sel_data = (paddr == MODEL_DATA_OFF);
	wire sel_cache = (paddr == CACHE_STAT_OFF);
	wire sel_range = (paddr == RANGE_STAT_OFF);
	wire sel_any = sel_ctrl | sel_status | sel_mask | sel_index | sel_data | sel_cache | sel_range;
	// writes land only in the access cycle of a mapped address
	wire wr_en = access_phase & pwrite & sel_any;
	wire wr_ctrl = wr_en & sel_ctrl;
	wire wr_status = wr_en & sel_status;
	wire wr_mask = wr_en & sel_mask;
	wire wr_index = wr_en & sel_index;
	wire wr_data = wr_en & sel_data;

	// instruction classification
	wire is_float = instr_valid & (instr_kind == KIND_FLOAT);
	wire is_wait = instr_valid & (instr_kind == KIND_WAIT);
	wire is_model_read = instr_valid & (instr_kind == KIND_MODEL_READ);
	wire is_model_write = instr_valid & (instr_kind == KIND_MODEL_WRITE);
	// a float instruction has exactly one outcome: trap, task-switch trap or issue
	wire float_trap = is_float & emulation_trap_flag;
	wire float_ts_trap = is_float & ~emulation_trap_flag & task_switched_flag;
	wire float_run = is_float & ~emulation_trap_flag & ~task_switched_flag;
	// wait honours the task-switched flag only under monitor-wait
	wire wait_trap = is_wait & monitor_wait_flag & task_switched_flag;
	wire wait_run = is_wait & ~wait_trap;
	wire fault_d = float_trap | float_ts_trap | wait_trap;

	// unmasked exception routing
	wire native_exc = fp_unmasked_exc & native_error_flag;
	wire external_exc = fp_unmasked_exc & ~native_error_flag;

	// control register: task switch sets the flag, set wins over a software clear
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d[MONITOR_WAIT_BIT] = pwdata[MONITOR_WAIT_BIT];
			ctrl_d[EMULATION_TRAP_BIT] = pwdata[EMULATION_TRAP_BIT];
			ctrl_d[TASK_SWITCHED_BIT] = pwdata[TASK_SWITCHED_BIT];
			ctrl_d[NATIVE_ERROR_BIT] = pwdata[NATIVE_ERROR_BIT];
			ctrl_d[NOT_WRITE_THROUGH_BIT] = pwdata[NOT_WRITE_THROUGH_BIT];
			ctrl_d[CACHE_DISABLE_BIT] = pwdata[CACHE_DISABLE_BIT];
		end
		if (task_switch) begin
			ctrl_d[TASK_SWITCHED_BIT] = 1'b1;
		end
	end

	// sticky events: a new event in the clearing cycle survives
	wire [EV_WIDTH-1:0] ev_set;
	assign ev_set[EV_DEV_FAULT] = fault_d;
	assign ev_set[EV_FP_ERROR] = native_exc;
	assign ev_set[EV_EXT_FP_IRQ] = external_exc;
	assign ev_set[EV_MODEL_WRITE] = is_model_write;
	// writing a one clears a status bit
	wire [EV_WIDTH-1:0] ev_clr = wr_status ? pwdata[EV_WIDTH-1:0] : '0;
	assign status_d = (status_q & ~ev_clr) | ev_set;

	// external request held until acknowledged; a new exception wins
	assign ext_irq_d = external_exc | (ext_irq_q & ~ext_irq_ack);

	// read data is captured in the setup cycle and shown in the access cycle,
	// so the word on prdata is settled a whole cycle before pready samples it
	wire [31:0] status_word = {{(32-EV_WIDTH){1'b0}}, status_q};
	wire [31:0] mask_word = {{(32-EV_WIDTH){1'b0}}, mask_q};
	wire [31:0] index_word = {{(32-MODEL_IDX_WIDTH){1'b0}}, index_q};
	wire [31:0] data_word = model_q[index_q];
	wire [31:0] range_word = {{(32-RANGE_COUNT){1'b0}}, range_uncached};
	wire [31:0] cache_word = {30'h0, any_valid, cache_enable};
	// an unmapped address reads as zero
	assign prdata_d = sel_ctrl ? ctrl_q :
		sel_status ? status_word :
		sel_mask ? mask_word :
		sel_index ? index_word :
		sel_data ? data_word :
		sel_cache ? cache_word :
		sel_range ? range_word :
		32'h0000_0000;

	// reset leaves every flag clear except the two cache flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RESET;
		end else if (ce) begin
			ctrl_q <= ctrl_d;
		end
	end

	// sticky status bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= EV_RESET;
		end else if (ce) begin
			status_q <= status_d;
		end
	end

	// mask shares the status layout
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= EV_RESET;
		end else if (ce && wr_mask) begin
			mask_q <= pwdata[EV_WIDTH-1:0];
		end
	end

	// index selects the model word behind the data offset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			index_q <= '0;
		end else if (ce && wr_index) begin
			index_q <= pwdata[MODEL_IDX_WIDTH-1:0];
		end
	end

	// only a read setup loads the capture flop, so writes leave prdata alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (ce && setup_phase && !pwrite) begin
			prdata_q <= prdata_d;
		end
	end

	// model register file; the core instruction has priority over the bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < MODEL_COUNT; i++) begin
				model_q[i] <= MODEL_RESET;
			end
		end else if (ce) begin
			if (is_model_write) begin
				model_q[instr_model_index] <= instr_model_wdata;
			end else if (wr_data) begin
				model_q[index_q] <= pwdata;
			end
		end
	end

	// read instruction result holds until the next read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			model_rdata_q <= 32'h0000_0000;
		end else if (ce && is_model_read) begin
			model_rdata_q <= model_q[instr_model_index];
		end
	end

	// one-cycle outcome pulses for each instruction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_q <= 1'b0;
		end else if (ce) begin
			fault_q <= fault_d;
		end
	end

	// float issued to the unit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fpu_issue_q <= 1'b0;
		end else if (ce) begin
			fpu_issue_q <= float_run;
		end
	end

	// wait completed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_done_q <= 1'b0;
		end else if (ce) begin
			wait_done_q <= wait_run;
		end
	end

	// instruction finished without a fault
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_done_q <= 1'b0;
		end else if (ce) begin
			instr_done_q <= instr_valid & ~fault_d;
		end
	end

	// native-mode error fault pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fp_error_q <= 1'b0;
		end else if (ce) begin
			fp_error_q <= native_exc;
		end
	end

	// external request held until acknowledged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_irq_q <= 1'b0;
		end else if (ce) begin
			ext_irq_q <= ext_irq_d;
		end
	end

	// a range register holding zero marks its range uncached
	genvar g;
	generate
		for (g = 0; g < RANGE_COUNT; g++) begin : g_range
			assign range_uncached[g] = (model_q[RANGE_FIRST + g] == UNCACHED_MEMORY_TYPE);
		end
	endgenerate

	// both cache flags must be clear; reset leaves the caches off
	assign cache_enable = ~cache_disable_flag & ~not_write_through_flag;

	// line valid bits; a flush wins over a fill in the same cycle
	cache_line_valid u_lines (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.cache_enable(cache_enable),
		.fill(line_fill),
		.fill_index(line_fill_index),
		.flush(cache_flush),
		.lookup_index(lookup_index),
		.lookup_valid(line_hit),
		.any_valid(any_valid)
	);

	// bus answer is combinational so a frozen clock enable never stalls the master
	assign pready = access_phase;
	assign pslverr = access_phase & ~sel_any;
	assign prdata = prdata_q;
	assign irq = |(status_q & mask_q);

	// registered instruction outcomes
	assign device_unavailable_fault = fault_q;
	assign fpu_issue = fpu_issue_q;
	assign wait_complete = wait_done_q;
	assign instr_done = instr_done_q;
	assign model_rdata = model_rdata_q;

	// exception routing outputs
	assign fp_error_fault = fp_error_q;
	assign ext_fp_irq = ext_irq_q;

endmodule : fpu_trap_and_cache_enable_control
`default_nettype wire

// file: rtl/fpu_trap_pkg.sv
// constants for the floating-point trap and cache enable control block
package fpu_trap_pkg;

	// register byte offsets on the APB bus
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] IRQ_STATUS_OFF = 8'h04;
	localparam logic [7:0] IRQ_MASK_OFF = 8'h08;
	localparam logic [7:0] MODEL_INDEX_OFF = 8'h0C;
	localparam logic [7:0] MODEL_DATA_OFF = 8'h10;
	localparam logic [7:0] CACHE_STAT_OFF = 8'h14;
	localparam logic [7:0] RANGE_STAT_OFF = 8'h18;

	// primary control register field positions
	localparam int MONITOR_WAIT_BIT = 1;
	localparam int EMULATION_TRAP_BIT = 2;
	localparam int TASK_SWITCHED_BIT = 3;
	localparam int NATIVE_ERROR_BIT = 5;
	localparam int NOT_WRITE_THROUGH_BIT = 29;
	localparam int CACHE_DISABLE_BIT = 30;

	// primary control register reset value: cache flags set, the rest clear
	localparam logic [31:0] CTRL_RESET = 32'h6000_0000;

	// interrupt status bit positions
	localparam int EV_DEV_FAULT = 0;
	localparam int EV_FP_ERROR = 1;
	localparam int EV_EXT_FP_IRQ = 2;
	localparam int EV_MODEL_WRITE = 3;
	localparam int EV_WIDTH = 4;
	localparam logic [EV_WIDTH-1:0] EV_RESET = 4'h0;

	// instruction kinds issued by the core
	localparam int KIND_WIDTH = 3;
	localparam logic [KIND_WIDTH-1:0] KIND_OTHER = 3'h0;
	localparam logic [KIND_WIDTH-1:0] KIND_FLOAT = 3'h1;
	localparam logic [KIND_WIDTH-1:0] KIND_WAIT = 3'h2;
	localparam logic [KIND_WIDTH-1:0] KIND_MODEL_READ = 3'h3;
	localparam logic [KIND_WIDTH-1:0] KIND_MODEL_WRITE = 3'h4;

	// model-specific register file; upper entries are the range registers
	localparam int MODEL_IDX_WIDTH = 3;
	localparam int MODEL_COUNT = 8;
	localparam int RANGE_FIRST = 4;
	localparam int RANGE_COUNT = 4;
	localparam logic [31:0] MODEL_RESET = 32'h0000_0000;
	localparam logic [31:0] UNCACHED_MEMORY_TYPE = 32'h0000_0000;

	// internal cache lines
	localparam int LINE_IDX_WIDTH = 4;
	localparam int LINE_COUNT = 16;

endpackage : fpu_trap_pkg

// file: tb/fpu_trap_chk.sv
// port assertions for the trap and cache control block
`timescale 1ns/1ps
`default_nettype none
module fpu_trap_chk
	import fpu_trap_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic instr_valid,
	input wire logic [KIND_WIDTH-1:0] instr_kind,
	input wire logic fp_unmasked_exc,
	input wire logic ext_irq_ack,
	input wire logic instr_done,
	input wire logic fpu_issue,
	input wire logic wait_complete,
	input wire logic device_unavailable_fault,
	input wire logic fp_error_fault,
	input wire logic ext_fp_irq,
	input wire logic cache_enable,
	input wire logic line_hit,
	input wire logic [RANGE_COUNT-1:0] range_uncached
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	float_outcome_a: assert property (
		ce && instr_valid && instr_kind == KIND_FLOAT |=> fpu_issue != device_unavailable_fault)
		else $error("float gave no single outcome");
	wait_outcome_a: assert property (
		ce && instr_valid && instr_kind == KIND_WAIT |=> wait_complete != device_unavailable_fault)
		else $error("wait gave no single outcome");
	fault_not_done_a: assert property (
		device_unavailable_fault |-> !instr_done && !fpu_issue && !wait_complete)
		else $error("fault with completion");
	idle_quiet_a: assert property (
		ce && !instr_valid |=> !fpu_issue && !wait_complete && !device_unavailable_fault)
		else $error("outcome without instruction");
	fp_route_a: assert property (
		ce && fp_unmasked_exc |=> fp_error_fault || ext_fp_irq)
		else $error("exception not routed");
	ext_hold_a: assert property (
		ce && ext_fp_irq && !ext_irq_ack && !fp_unmasked_exc |=> ext_fp_irq)
		else $error("external request dropped");
	ext_ack_a: assert property (
		ce && ext_irq_ack && !fp_unmasked_exc |=> !ext_fp_irq)
		else $error("external request not cleared");
	hit_enabled_a: assert property (
		line_hit |-> cache_enable)
		else $error("hit while cache disabled");
	reset_state_a: assert property (
		$rose(presetn) |-> !cache_enable && !line_hit && range_uncached == 4'hF)
		else $error("bad state after reset");
endmodule : fpu_trap_chk
bind fpu_trap_and_cache_enable_control fpu_trap_chk chk (.pclk(pclk), .presetn(presetn),
	.ce(ce), .instr_valid(instr_valid), .instr_kind(instr_kind),
	.fp_unmasked_exc(fp_unmasked_exc), .ext_irq_ack(ext_irq_ack), .instr_done(instr_done),
	.fpu_issue(fpu_issue), .wait_complete(wait_complete),
	.device_unavailable_fault(device_unavailable_fault), .fp_error_fault(fp_error_fault),
	.ext_fp_irq(ext_fp_irq), .cache_enable(cache_enable), .line_hit(line_hit),
	.range_uncached(range_uncached));
`default_nettype wire

// file: tb/test_fpu_trap_and_cache_enable_control.sv
// self-checking bench for the trap and cache control block
`timescale 1ns/1ps
`default_nettype none
module test_fpu_trap_and_cache_enable_control
	import fpu_trap_pkg::*;
;
	localparam logic [31:0] TRAP_V = 32'h0000_0001 << EMULATION_TRAP_BIT;
	localparam logic [31:0] MONW_V = 32'h0000_0001 << MONITOR_WAIT_BIT;
	localparam logic [31:0] TSW_V = 32'h0000_0001 << TASK_SWITCHED_BIT;
	localparam logic [31:0] NATE_V = 32'h0000_0001 << NATIVE_ERROR_BIT;
	localparam logic [31:0] CDIS_V = 32'h0000_0001 << CACHE_DISABLE_BIT;
	localparam logic [31:0] NWT_V = 32'h0000_0001 << NOT_WRITE_THROUGH_BIT;
	logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, instr_model_wdata = 32'h0000_0000;
	logic instr_valid = 1'b0, task_switch = 1'b0, fp_unmasked_exc = 1'b0, ext_irq_ack = 1'b0;
	logic line_fill = 1'b0, cache_flush = 1'b0;
	logic [KIND_WIDTH-1:0] instr_kind = KIND_OTHER;
	logic [MODEL_IDX_WIDTH-1:0] instr_model_index = 3'h0;
	logic [LINE_IDX_WIDTH-1:0] line_fill_index = 4'h0, lookup_index = 4'h0;
	logic [31:0] prdata, model_rdata, r, o;
	logic pready, pslverr, irq, instr_done, fpu_issue, wait_complete, device_unavailable_fault;
	logic fp_error_fault, ext_fp_irq, cache_enable, line_hit, e;
	logic [RANGE_COUNT-1:0] range_uncached;
	int n_fail = 0, total_checks = 0;
	fpu_trap_and_cache_enable_control dut (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.instr_valid(instr_valid), .instr_kind(instr_kind), .instr_model_index(instr_model_index),
		.instr_model_wdata(instr_model_wdata), .task_switch(task_switch),
		.instr_done(instr_done), .fpu_issue(fpu_issue), .wait_complete(wait_complete),
		.device_unavailable_fault(device_unavailable_fault), .model_rdata(model_rdata),
		.fp_unmasked_exc(fp_unmasked_exc), .ext_irq_ack(ext_irq_ack),
		.fp_error_fault(fp_error_fault), .ext_fp_irq(ext_fp_irq), .line_fill(line_fill),
		.line_fill_index(line_fill_index), .cache_flush(cache_flush),
		.lookup_index(lookup_index), .cache_enable(cache_enable), .line_hit(line_hit),
		.range_uncached(range_uncached));
	always #12.5 pclk = ~pclk;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task conclude;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude
	// one apb transfer; read data and error taken at the ready edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask : apb
	task rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(r, exp);
	endtask : rd
	task ins(input logic [KIND_WIDTH-1:0] k, input logic [2:0] i, input logic [31:0] d);
		@(posedge pclk);
		instr_valid <= 1'b1;
		instr_kind <= k;
		instr_model_index <= i;
		instr_model_wdata <= d;
		@(posedge pclk);
		instr_valid <= 1'b0;
		#1 o = {28'h0, fpu_issue, wait_complete, device_unavailable_fault, instr_done};
	endtask : ins
	task run(input logic [31:0] c, input logic [KIND_WIDTH-1:0] k, input logic [31:0] exp);
		apb(1'b1, CTRL_OFF, c);
		ins(k, 3'h0, 32'h0000_0000);
		chk(o, exp);
	endtask : run
	task fpx(input logic ack);
		@(posedge pclk);
		fp_unmasked_exc <= !ack;
		ext_irq_ack <= ack;
		@(posedge pclk);
		fp_unmasked_exc <= 1'b0;
		ext_irq_ack <= 1'b0;
		#1 o = {30'h0, fp_error_fault, ext_fp_irq};
	endtask : fpx
	task t_reset;
		rd(CTRL_OFF, CTRL_RESET);
		rd(CACHE_STAT_OFF, 32'h0000_0000);
		rd(RANGE_STAT_OFF, 32'h0000_000F);
		$display("reset test done");
	endtask : t_reset
	task t_instr;
		run(32'h0000_0000, KIND_FLOAT, 32'h0000_0009);
		run(TRAP_V, KIND_FLOAT, 32'h0000_0002);
		run(TRAP_V | TSW_V | NATE_V, KIND_WAIT, 32'h0000_0005);
		run(TSW_V, KIND_FLOAT, 32'h0000_0002);
		run(TSW_V, KIND_WAIT, 32'h0000_0005);
		run(TSW_V | MONW_V, KIND_WAIT, 32'h0000_0002);
		run(MONW_V, KIND_WAIT, 32'h0000_0005);
		@(posedge pclk);
		task_switch <= 1'b1;
		@(posedge pclk);
		task_switch <= 1'b0;
		ins(KIND_WAIT, 3'h0, 32'h0000_0000);
		chk(o, 32'h0000_0002);
		@(posedge pclk);
		ce <= 1'b0;
		ins(KIND_FLOAT, 3'h0, 32'h0000_0000);
		chk(o, 32'h0000_0000);
		@(posedge pclk);
		ce <= 1'b1;
		$display("instruction test done");
	endtask : t_instr
	task t_irq;
		rd(IRQ_STATUS_OFF, 32'h0000_0001);
		chk({31'h0, irq}, 32'h0000_0000);
		apb(1'b1, IRQ_MASK_OFF, 32'h0000_0001);
		@(posedge pclk);
		#1 chk({31'h0, irq}, 32'h0000_0001);
		apb(1'b1, IRQ_STATUS_OFF, 32'h0000_0001);
		@(posedge pclk);
		#1 chk({31'h0, irq}, 32'h0000_0000);
		rd(8'h40, 32'h0000_0000);
		chk({31'h0, e}, 32'h0000_0001);
		$display("interrupt test done");
	endtask : t_irq
	task t_fpexc;
		apb(1'b1, CTRL_OFF, NATE_V);
		fpx(1'b0);
		chk(o, 32'h0000_0002);
		apb(1'b1, CTRL_OFF, 32'h0000_0000);
		fpx(1'b0);
		chk(o, 32'h0000_0001);
		repeat (3) @(posedge pclk);
		#1 chk({31'h0, ext_fp_irq}, 32'h0000_0001);
		fpx(1'b1);
		chk(o, 32'h0000_0000);
		$display("fp exception test done");
	endtask : t_fpexc
	task t_cache;
		apb(1'b1, CTRL_OFF, CDIS_V);
		chk({31'h0, cache_enable}, 32'h0000_0000);
		apb(1'b1, CTRL_OFF, NWT_V);
		chk({31'h0, cache_enable}, 32'h0000_0000);
		apb(1'b1, CTRL_OFF, 32'h0000_0000);
		rd(CACHE_STAT_OFF, 32'h0000_0001);
		@(posedge pclk);
		line_fill <= 1'b1;
		line_fill_index <= 4'h3;
		lookup_index <= 4'h3;
		@(posedge pclk);
		line_fill <= 1'b0;
		#1 chk({31'h0, line_hit}, 32'h0000_0001);
		@(posedge pclk);
		lookup_index <= 4'h4;
		cache_flush <= 1'b1;
		@(posedge pclk);
		lookup_index <= 4'h3;
		cache_flush <= 1'b0;
		#1 chk({31'h0, line_hit}, 32'h0000_0000);
		$display("cache test done");
	endtask : t_cache
	task t_model;
		ins(KIND_MODEL_WRITE, 3'h5, 32'h0000_1234);
		chk({28'h0, range_uncached}, 32'h0000_000D);
		ins(KIND_MODEL_READ, 3'h5, 32'h0000_0000);
		chk(model_rdata, 32'h0000_1234);
		apb(1'b1, MODEL_INDEX_OFF, 32'h0000_0005);
		rd(MODEL_DATA_OFF, 32'h0000_1234);
		apb(1'b1, MODEL_DATA_OFF, 32'h0000_0000);
		rd(RANGE_STAT_OFF, 32'h0000_000F);
		rd(IRQ_STATUS_OFF, 32'h0000_000E);
		$display("model register test done");
	endtask : t_model
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_instr;
		t_irq;
		t_fpexc;
		t_cache;
		t_model;
		conclude;
	end
	// watchdog against a hang
	initial begin
		#200000;
		n_fail++;
		conclude;
	end
endmodule : test_fpu_trap_and_cache_enable_control
`default_nettype wire
